// File: emc_pkg.sv
// constants, register layout and types for the async static-memory bank
// assumes a single pclk domain; included by every design file of the bank
package emc_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] EMC_OFF_CTRL = 12'h000;
   localparam logic [11:0] EMC_OFF_RTMG = 12'h004;
   localparam logic [11:0] EMC_OFF_WTMG = 12'h008;
   localparam logic [11:0] EMC_OFF_STAT = 12'h00c;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int EMC_BANK_EN = 0;
   localparam int EMC_MUX_EN = 1;
   localparam int EMC_TYPE_LSB = 2;
   localparam int EMC_WIDTH_LSB = 4;
   localparam int EMC_NOR_EN = 6;
   localparam int EMC_SYNC_BURST = 8;
   localparam int EMC_WRAP_EN = 10;
   localparam int EMC_WR_EN = 12;
   localparam int EMC_SYNC_WAIT = 13;
   localparam int EMC_SPLIT = 14;
   localparam logic [1:0] EMC_TYPE_NOR = 2'h2;
   localparam logic [1:0] EMC_WIDTH_8 = 2'h0;

   // ----------------------------------------------------------------
   // timing register fields
   // ----------------------------------------------------------------
   localparam int EMC_ADDR_LSB = 0;
   localparam int EMC_AHOLD_LSB = 4;
   localparam int EMC_DATA_LSB = 8;
   localparam int EMC_BUS_LSB = 16;
   localparam int EMC_MODE_LSB = 28;
   localparam logic [1:0] EMC_MODE_A = 2'h0;
   localparam logic [1:0] EMC_MODE_B = 2'h1;
   localparam logic [1:0] EMC_MODE_C = 2'h2;
   localparam logic [1:0] EMC_MODE_D = 2'h3;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [31:0] EMC_CTRL_RST = 32'h0000_0080;
   localparam logic [31:0] EMC_TMG_RST = 32'h000f_ffff;
   localparam logic [31:0] EMC_CTRL_WMASK = 32'h000f_ff7f;
   localparam logic [31:0] EMC_CTRL_FIXED = 32'h0000_0080;
   localparam logic [31:0] EMC_RTMG_WMASK = 32'h3fff_ffff;
   localparam logic [31:0] EMC_WTMG_WMASK = 32'h300f_ffff;

   // ----------------------------------------------------------------
   // status register fields
   // ----------------------------------------------------------------
   localparam int EMC_STAT_BUSY = 0;
   localparam int EMC_STAT_MODE_LSB = 1;
   localparam int EMC_STAT_WRITE = 3;

   typedef enum logic [1:0] {
      EMC_ST_IDLE,
      EMC_ST_ADDR,
      EMC_ST_DATA,
      EMC_ST_TURN
   } emc_state_t;

endpackage

// File: emc_phase_timer.sv
// down-counter that times one phase of an external access
// assumes the loader holds load for one cycle; runs on pclk only
`timescale 1ns/10ps
`default_nettype none

module emc_phase_timer
   import emc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic [7:0] load_val,
   output logic [7:0] count,
   output logic expired
);

   typedef struct packed {
      logic [7:0] cnt;
   } emc_tmr_t;

   emc_tmr_t st_reg;
   emc_tmr_t st_next;

   always_comb begin
      st_next = st_reg;
      if (load) begin
         st_next.cnt = load_val;
      end else if (st_reg.cnt != 8'h00) begin
         st_next.cnt = st_reg.cnt - 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign count = st_reg.cnt;
   // a phase loaded with n lasts n+1 cycles
   assign expired = (st_reg.cnt == 8'h00);

endmodule // emc_phase_timer

`default_nettype wire

// File: emc_async_bank.sv
// async static-memory bank with separate read and write timing sets
// assumes an APB master on pclk and a same-clock requester that holds
// mem_req with its fields until mem_ack; memory pins are split in/out/oe
//
// Operation
// - reads always take their phase lengths from the read timing reg.
// - with split timing on, writes take phases from the write timing reg.
// - read and write directions each pick their own mode, A to D.
// - control bit 14 set to one turns on split read/write timing.
// - timing mode field bits 29:28 equal to zero selects mode A.
// - mode field value one selects mode B, used with NOR access on.
// - mode A runs with NOR access off and any non-NOR memory type.
// - bus turnaround bits 19:16 set the chip-select high gap.
// - data phase bits 15:8 set the data phase length per direction.
// - addr phase bits 3:0 set the address phase; addr hold stays zero.
// - sync burst, wrap, sync wait, latency and divider stay zero.
// - data width bits 5:4 set the memory data path width.
// - bank enable bit 0 must be one; bit 7 reads one, mux bit stays 0.
// - write enable bit 12 gates whether writes reach the memory.
// - mode field value two selects mode C, NOR access and split on.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module emc_async_bank
   import emc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [23:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [1:0] mem_be,
   output logic mem_ack,
   output logic mem_err,
   output logic [15:0] mem_rdata,
   output logic chip_select_n,
   output logic addr_valid_n,
   output logic out_enable_n,
   output logic write_enable_n,
   output logic lower_byte_n,
   output logic upper_byte_n,
   output logic [23:0] mem_addr_out,
   output logic [15:0] mem_data_out,
   output logic mem_data_oe,
   input wire logic [15:0] mem_data_in
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      emc_state_t state;
      logic [31:0] ctrl;
      logic [31:0] rtmg;
      logic [31:0] wtmg;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic cs_n;
      logic adv_n;
      logic oe_n;
      logic we_n;
      logic lb_n;
      logic ub_n;
      logic [23:0] addr;
      logic [15:0] dout;
      logic doe;
      logic ack;
      logic err;
      logic [15:0] rdata;
      logic cur_we;
      logic [1:0] cur_mode;
      logic [7:0] cur_data;
      logic [3:0] cur_bus;
      logic [15:0] din_s1;
      logic [15:0] din_s2;
   } emc_bank_t;

   emc_bank_t st_reg;
   emc_bank_t st_next;

   logic tmr_load;
   logic [7:0] tmr_val;
   logic [7:0] tmr_count;
   logic tmr_expired;

   emc_phase_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .load(tmr_load),
      .load_val(tmr_val),
      .count(tmr_count),
      .expired(tmr_expired)
   );

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   logic [31:0] byte_mask;
   logic [31:0] wr_merge;
   logic [31:0] rd_word;
   logic [31:0] sel_tmg;
   logic [31:0] status;
   logic addr_ok;
   logic apb_setup;
   logic apb_commit;

   assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                       {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign apb_setup = psel && !penable && !st_reg.pready;
   assign apb_commit = psel && penable && st_reg.pready;
   assign addr_ok = (paddr == EMC_OFF_CTRL) || (paddr == EMC_OFF_RTMG) ||
                    (paddr == EMC_OFF_WTMG) || (paddr == EMC_OFF_STAT);

   always_comb begin
      status = '0;
      status[EMC_STAT_BUSY] = (st_reg.state != EMC_ST_IDLE);
      status[EMC_STAT_MODE_LSB +: 2] = st_reg.cur_mode;
      status[EMC_STAT_WRITE] = st_reg.cur_we &&
                               (st_reg.state != EMC_ST_IDLE);
   end

   always_comb begin
      case (paddr)
         EMC_OFF_CTRL: rd_word = st_reg.ctrl;
         EMC_OFF_RTMG: rd_word = st_reg.rtmg;
         EMC_OFF_WTMG: rd_word = st_reg.wtmg;
         EMC_OFF_STAT: rd_word = status;
         default: rd_word = '0;
      endcase
   end

   // timing set for the pending request
   always_comb begin
      if (mem_we && st_reg.ctrl[EMC_SPLIT]) begin
         sel_tmg = st_reg.wtmg;
      end else begin
         sel_tmg = st_reg.rtmg;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      tmr_load = 1'b0;
      tmr_val = 8'h00;
      wr_merge = pwdata & byte_mask;
      st_next.ack = 1'b0;
      st_next.err = 1'b0;
      st_next.din_s1 = mem_data_in;
      st_next.din_s2 = st_reg.din_s1;

      // apb: setup cycle prepares the answer, access cycle commits
      if (apb_setup) begin
         st_next.pready = 1'b1;
         st_next.pslverr = !addr_ok;
         st_next.prdata = pwrite ? 32'h0000_0000 : rd_word;
      end else if (apb_commit) begin
         st_next.pready = 1'b0;
         st_next.pslverr = 1'b0;
         st_next.prdata = 32'h0000_0000;
      end
      // fields for sync features are stored only; the bank never acts
      // on them, software keeps them zero
      if (apb_commit && pwrite) begin
         case (paddr)
            EMC_OFF_CTRL: begin
               st_next.ctrl = ((st_reg.ctrl & ~(byte_mask &
                              EMC_CTRL_WMASK)) | (wr_merge &
                              EMC_CTRL_WMASK)) | EMC_CTRL_FIXED;
            end
            EMC_OFF_RTMG: begin
               st_next.rtmg = (st_reg.rtmg & ~(byte_mask &
                              EMC_RTMG_WMASK)) | (wr_merge &
                              EMC_RTMG_WMASK);
            end
            EMC_OFF_WTMG: begin
               st_next.wtmg = (st_reg.wtmg & ~(byte_mask &
                              EMC_WTMG_WMASK)) | (wr_merge &
                              EMC_WTMG_WMASK);
            end
            default: begin
               st_next.ctrl = st_reg.ctrl;
            end
         endcase
      end

      case (st_reg.state)
         EMC_ST_IDLE: begin
            if (mem_req && !st_reg.ack && !st_reg.err) begin
               if (!st_reg.ctrl[EMC_BANK_EN]) begin
                  st_next.err = 1'b1;
               end else if (mem_we && !st_reg.ctrl[EMC_WR_EN]) begin
                  st_next.err = 1'b1;
               end else begin
                  // whole timing set is latched; later register
                  // writes only affect the next access
                  st_next.cur_we = mem_we;
                  st_next.cur_mode = sel_tmg[EMC_MODE_LSB +: 2];
                  st_next.cur_data = sel_tmg[EMC_DATA_LSB +: 8];
                  st_next.cur_bus = sel_tmg[EMC_BUS_LSB +: 4];
                  tmr_load = 1'b1;
                  tmr_val = {4'h0, sel_tmg[EMC_ADDR_LSB +: 4]};
                  st_next.cs_n = 1'b0;
                  st_next.addr = mem_addr;
                  st_next.dout = mem_wdata;
                  if (st_reg.ctrl[EMC_WIDTH_LSB +: 2] == EMC_WIDTH_8) begin
                     st_next.lb_n = 1'b0;
                     st_next.ub_n = 1'b1;
                  end else begin
                     st_next.lb_n = !mem_be[0];
                     st_next.ub_n = !mem_be[1];
                  end
                  // address strobe only for nor-style modes b, c, d
                  case (sel_tmg[EMC_MODE_LSB +: 2])
                     EMC_MODE_A: st_next.adv_n = 1'b1;
                     EMC_MODE_B: st_next.adv_n =
                        !st_reg.ctrl[EMC_NOR_EN];
                     EMC_MODE_C: st_next.adv_n =
                        !st_reg.ctrl[EMC_NOR_EN];
                     EMC_MODE_D: st_next.adv_n =
                        !st_reg.ctrl[EMC_NOR_EN];
                     default: st_next.adv_n = 1'b1;
                  endcase
                  st_next.state = EMC_ST_ADDR;
               end
            end
         end
         EMC_ST_ADDR: begin
            if (tmr_expired) begin
               tmr_load = 1'b1;
               tmr_val = st_reg.cur_data;
               st_next.adv_n = 1'b1;
               st_next.oe_n = st_reg.cur_we;
               st_next.we_n = !st_reg.cur_we;
               st_next.doe = st_reg.cur_we;
               st_next.state = EMC_ST_DATA;
            end
         end
         EMC_ST_DATA: begin
            if (tmr_expired) begin
               st_next.rdata = st_reg.cur_we ? st_reg.rdata : st_reg.din_s2;
               st_next.ack = 1'b1;
               st_next.cs_n = 1'b1;
               st_next.oe_n = 1'b1;
               st_next.we_n = 1'b1;
               st_next.doe = 1'b0;
               st_next.lb_n = 1'b1;
               st_next.ub_n = 1'b1;
               tmr_load = 1'b1;
               tmr_val = {4'h0, st_reg.cur_bus};
               st_next.state = EMC_ST_TURN;
            end else if (tmr_count == 8'h01 && st_reg.cur_we) begin
               // write strobe rises one cycle before the phase ends
               // so data holds past it
               st_next.we_n = 1'b1;
            end
         end
         EMC_ST_TURN: begin
            if (tmr_expired) begin
               st_next.state = EMC_ST_IDLE;
            end
         end
         default: begin
            st_next.state = EMC_ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.state <= EMC_ST_IDLE;
         st_reg.ctrl <= EMC_CTRL_RST;
         st_reg.rtmg <= EMC_TMG_RST;
         st_reg.wtmg <= EMC_TMG_RST;
         st_reg.cs_n <= 1'b1;
         st_reg.adv_n <= 1'b1;
         st_reg.oe_n <= 1'b1;
         st_reg.we_n <= 1'b1;
         st_reg.lb_n <= 1'b1;
         st_reg.ub_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign mem_ack = st_reg.ack;
   assign mem_err = st_reg.err;
   assign mem_rdata = st_reg.rdata;
   assign chip_select_n = st_reg.cs_n;
   assign addr_valid_n = st_reg.adv_n;
   assign out_enable_n = st_reg.oe_n;
   assign write_enable_n = st_reg.we_n;
   assign lower_byte_n = st_reg.lb_n;
   assign upper_byte_n = st_reg.ub_n;
   assign mem_addr_out = st_reg.addr;
   assign mem_data_out = st_reg.dout;
   assign mem_data_oe = st_reg.doe;

endmodule // emc_async_bank

`default_nettype wire

// File: emc_async_bank_checker.sv
// checker for apb answers and memory pin sequencing of the async bank
// assumes one pclk domain; bound to every emc_async_bank
`timescale 1ns/10ps
`default_nettype none

module emc_async_bank_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic mem_ack,
   input wire logic mem_err,
   input wire logic chip_select_n,
   input wire logic addr_valid_n,
   input wire logic out_enable_n,
   input wire logic write_enable_n,
   input wire logic [23:0] mem_addr_out,
   input wire logic mem_data_oe
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_cs_up;
      $rose(chip_select_n);
   endsequence
   a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
      else $error("apb answer not one cycle after setup");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("slave error outside access cycle");
   a_ack_ends_cs: assert property (mem_ack |-> s_cs_up)
      else $error("ack not at chip select release");
   a_cs_gap_min: assert property (s_cs_up |=> chip_select_n)
      else $error("chip select gap too short");
   a_err_quiet_pins: assert property (mem_err |->
      chip_select_n && $past(chip_select_n))
      else $error("refused request touched pins");
   a_oe_read_only: assert property (!out_enable_n |->
      !chip_select_n && write_enable_n && addr_valid_n)
      else $error("output enable outside read data phase");
   a_we_drives_bus: assert property (!write_enable_n |->
      mem_data_oe && !chip_select_n && out_enable_n)
      else $error("write strobe without driven bus");
   a_addr_held: assert property (!chip_select_n && !$past(chip_select_n)
      |-> $stable(mem_addr_out))
      else $error("address moved during access");
   a_ack_single: assert property (mem_ack |=> !mem_ack && !mem_err)
      else $error("ack longer than one cycle");
   a_adv_at_start: assert property ($fell(addr_valid_n)
      |-> $fell(chip_select_n))
      else $error("address strobe not at access start");
endmodule // emc_async_bank_checker

bind emc_async_bank emc_async_bank_checker i_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .mem_ack(mem_ack), .mem_err(mem_err),
   .chip_select_n(chip_select_n), .addr_valid_n(addr_valid_n),
   .out_enable_n(out_enable_n), .write_enable_n(write_enable_n),
   .mem_addr_out(mem_addr_out), .mem_data_oe(mem_data_oe));
`default_nettype wire

// File: emc_mem_model.sv
// behavioural async sram on the far side of the bank
// assumes pins as driven by emc_async_bank; unwritten words read ~addr
`timescale 1ns/10ps
`default_nettype none

module emc_mem_model (
   input wire logic pclk,
   input wire logic chip_select_n,
   input wire logic addr_valid_n,
   input wire logic out_enable_n,
   input wire logic write_enable_n,
   input wire logic lower_byte_n,
   input wire logic upper_byte_n,
   input wire logic [23:0] mem_addr_out,
   input wire logic [15:0] mem_data_out,
   output logic [15:0] mem_data_in,
   output logic adv_seen
);
   logic [15:0] mem [int];
   logic [15:0] flip = 16'h5a5a;
   logic we_q = 1'b1;
   logic cs_q = 1'b1;
   initial adv_seen = 1'b0;
   // released bus toggles so a stale capture cannot match
   always @* begin
      if (!chip_select_n && !out_enable_n)
         mem_data_in = mem.exists(mem_addr_out) ?
            mem[mem_addr_out] : ~mem_addr_out[15:0];
      else
         mem_data_in = flip;
   end
   always @(posedge pclk) begin
      flip <= ~flip;
      we_q <= write_enable_n;
      cs_q <= chip_select_n;
      if (cs_q && !chip_select_n)
         adv_seen <= !addr_valid_n;
      else if (!addr_valid_n)
         adv_seen <= 1'b1;
      if (!we_q && write_enable_n && !chip_select_n) begin
         if (!mem.exists(mem_addr_out))
            mem[mem_addr_out] = ~mem_addr_out[15:0];
         if (!lower_byte_n)
            mem[mem_addr_out][7:0] = mem_data_out[7:0];
         if (!upper_byte_n)
            mem[mem_addr_out][15:8] = mem_data_out[15:8];
      end
   end
endmodule // emc_mem_model
`default_nettype wire

// File: testbench.sv
// self-checking bench: apb register master, memory requester, sram model
// assumes the checker is bound in its own file
`timescale 1ns/10ps
`default_nettype none

module testbench
   import emc_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, er, mem_ack, mem_err, adv_seen;
   logic mem_req = 1'b0, mem_we = 1'b0;
   logic [23:0] mem_addr = 24'h0, mem_addr_out, a;
   logic [15:0] mem_wdata = 16'h0, mem_rdata, mem_data_out, mem_data_in, d;
   logic [1:0] mem_be = 2'h3, b;
   logic chip_select_n, addr_valid_n, out_enable_n, write_enable_n;
   logic lower_byte_n, upper_byte_n, mem_data_oe;
   logic [15:0] model [int];
   int n_mismatch = 0, check_count = 0, seed = 18, n, gap = 0, hi = 0;
   always #12.5 pclk = ~pclk;
   emc_async_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
      .mem_err(mem_err), .mem_rdata(mem_rdata),
      .chip_select_n(chip_select_n), .addr_valid_n(addr_valid_n),
      .out_enable_n(out_enable_n), .write_enable_n(write_enable_n),
      .lower_byte_n(lower_byte_n), .upper_byte_n(upper_byte_n),
      .mem_addr_out(mem_addr_out), .mem_data_out(mem_data_out),
      .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in));
   emc_mem_model i_mem (.pclk(pclk), .chip_select_n(chip_select_n),
      .addr_valid_n(addr_valid_n), .out_enable_n(out_enable_n),
      .write_enable_n(write_enable_n), .lower_byte_n(lower_byte_n),
      .upper_byte_n(upper_byte_n), .mem_addr_out(mem_addr_out),
      .mem_data_out(mem_data_out), .mem_data_in(mem_data_in),
      .adv_seen(adv_seen));
   // ----------------------------------------------------------------
   // chip select high run before each falling edge
   // ----------------------------------------------------------------
   always @(posedge pclk) begin
      if (chip_select_n) begin
         hi <= hi + 1;
      end else begin
         if (hi != 0) gap <= hi;
         hi <= 0;
      end
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(logic w, logic [11:0] ad, logic [31:0] wd);
      int t;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
      @(posedge pclk) penable <= 1'b1;
      t = 0;
      do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
      if (t >= 50) n_mismatch++;
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // n counts edges with chip select low until ack or err is sampled;
   // a wait for the previous turnaround does not add to it
   task automatic acc(logic w, logic [23:0] ad, logic [15:0] wd,
      logic [1:0] be);
      int t;
      @(posedge pclk);
      mem_req <= 1'b1; mem_we <= w; mem_addr <= ad;
      mem_wdata <= wd; mem_be <= be;
      n = 0;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
         if (chip_select_n === 1'b0) n++;
      end while (mem_ack !== 1'b1 && mem_err !== 1'b1 && t < 200);
      if (t >= 200) n_mismatch++;
      er = mem_err; rd = {16'h0, mem_rdata};
      mem_req <= 1'b0;
   endtask
   function automatic logic [31:0] bm_rd(logic [23:0] ad);
      return {16'h0, model.exists(ad) ? model[ad] : ~ad[15:0]};
   endfunction
   // 8-bit bus writes only the low lane whatever the enables say
   task automatic bm_wr(logic [23:0] ad, logic [15:0] wd, logic [1:0] be,
      logic w8);
      logic [15:0] v;
      v = bm_rd(ad);
      if (w8) be = 2'b01;
      if (be[0]) v[7:0] = wd[7:0];
      if (be[1]) v[15:8] = wd[15:8];
      model[ad] = v;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, EMC_OFF_CTRL, 32'h0); chk("ctrl", EMC_CTRL_RST, rd);
      apb(1'b0, EMC_OFF_RTMG, 32'h0); chk("rtmg", EMC_TMG_RST, rd);
      apb(1'b0, EMC_OFF_WTMG, 32'h0); chk("wtmg", EMC_TMG_RST, rd);
      apb(1'b0, EMC_OFF_STAT, 32'h0); chk("stat", 32'h0, rd);
      apb(1'b0, 12'h010, 32'h0); chk("unmapped", 32'h1, er);
      chk("unmapped_rd", 32'h0, rd);
      apb(1'b1, EMC_OFF_WTMG, '1); apb(1'b0, EMC_OFF_WTMG, 32'h0);
      chk("wtmg_mask", EMC_WTMG_WMASK, rd);
      apb(1'b1, EMC_OFF_CTRL, '1); apb(1'b0, EMC_OFF_CTRL, 32'h0);
      chk("ctrl_mask", EMC_CTRL_WMASK | EMC_CTRL_FIXED, rd);
      $display("test registers done");
      // nor, 16-bit, write on, split on; reads mode B, writes mode A
      apb(1'b1, EMC_OFF_CTRL, 32'h0000_50d9);
      apb(1'b1, EMC_OFF_RTMG, 32'h1001_0201);
      apb(1'b1, EMC_OFF_WTMG, 32'h0002_0302);
      for (int i = 0; i < 4; i++) begin
         a = 24'($random(seed)); d = 16'($random(seed));
         b = 2'($random(seed));
         acc(1'b1, a, d, b);
         chk("wr_cyc", (2 + 1) + (3 + 1), n);
         chk("wr_adv", 32'h0, adv_seen);
         bm_wr(a, d, b, 1'b0);
         acc(1'b0, a, 16'h0, 2'h3);
         chk("rd_cyc", (1 + 1) + (2 + 1), n);
         chk("rd_data", bm_rd(a), rd);
         chk("rd_adv", 32'h1, adv_seen);
         chk("cs_gap", 32'h1, gap >= 2 + 2);
      end
      $display("test split timing done");
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, EMC_OFF_RTMG, {2'b00, m[1:0], 28'h001_0201});
         acc(1'b0, a, 16'h0, 2'h3);
         chk("mode_cyc", (1 + 1) + (2 + 1), n);
         chk("mode_adv", m != 0, adv_seen);
      end
      apb(1'b0, EMC_OFF_STAT, 32'h0);
      chk("stat_mode", 32'(EMC_MODE_D) << EMC_STAT_MODE_LSB, rd);
      $display("test modes done");
      apb(1'b1, EMC_OFF_CTRL, 32'h0000_10d9);
      d = 16'($random(seed));
      acc(1'b1, a, d, 2'h3);
      chk("nosplit_cyc", (1 + 1) + (2 + 1), n);
      chk("nosplit_adv", 32'h1, adv_seen);
      bm_wr(a, d, 2'h3, 1'b0);
      apb(1'b1, EMC_OFF_CTRL, 32'h0000_50c9);
      d = 16'($random(seed));
      acc(1'b1, a, d, 2'h3); bm_wr(a, d, 2'h3, 1'b1);
      apb(1'b1, EMC_OFF_CTRL, 32'h0000_50d9);
      acc(1'b0, a, 16'h0, 2'h3); chk("w8_data", bm_rd(a), rd);
      $display("test width and timing select done");
      apb(1'b1, EMC_OFF_CTRL, 32'h0000_40d9);
      acc(1'b1, a, 16'hffff, 2'h3); chk("wr_off_err", 32'h1, er);
      acc(1'b0, a, 16'h0, 2'h3); chk("wr_off_rd", bm_rd(a), rd);
      apb(1'b1, EMC_OFF_CTRL, 32'h0000_40d8);
      acc(1'b0, a, 16'h0, 2'h3); chk("bank_off_err", 32'h1, er);
      $display("test refusals done");
      end_sim;
   end
   // run needs a few hundred cycles; the 40000-cycle limit leaves ample margin
   initial begin
      #(25 * 40000);
      n_mismatch++;
      end_sim;
   end
endmodule // testbench
`default_nettype wire
